// ==== inc/spe_pkg.sv ====
// shared constants and types of the serial port engine
// assumes a single 200 MHz clock and plain-port configuration

package spe_pkg;

  // ***********************************************************
  // sizes
  // ***********************************************************
  localparam int SPE_WORD_W     = 8;
  localparam int SPE_FIFO_DEPTH = 16;
  localparam int SPE_NUM_CS     = 4;
  localparam int SPE_CS_W       = 2;
  localparam int SPE_DIV_W      = 8;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [SPE_DIV_W-1:0] SPE_DIV_RESET  = 8'h00;
  localparam logic [SPE_DIV_W-1:0] SPE_DIV_ONE    = 8'h01;
  localparam logic                 SPE_MFD_RESET  = 1'b0;
  localparam logic                 SPE_MSTR_RESET = 1'b0;
  localparam logic                 SPE_TXE_RESET  = 1'b1;

  // ***********************************************************
  // timing counts, in divided clock half periods; the last one in bits
  // ***********************************************************
  localparam logic [4:0] SPE_LAST_HALF  = 5'h0f;  // 8 bits, 16 halves
  localparam logic [4:0] SPE_LAST_EXTRA = 5'h01;  // one spurious pulse
  localparam logic [2:0] SPE_LAST_BIT   = 3'h7;

  // master sequencer states
  typedef enum logic [2:0] {
    SPE_ST_IDLE  = 3'b001,
    SPE_ST_EXTRA = 3'b010,
    SPE_ST_SHIFT = 3'b100
  } spe_state_type;

endpackage

// ==== core/spe_fifo.sv ====
// transmit word buffer with a registered head word
// assumes one clock; flush acts like a synchronous clear

`timescale 1ns/1ps

module spe_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          head_v_q;
  logic [W-1:0]  head_q;
  wire           push = in_valid && in_ready;
  wire           load = (cnt_q != '0) && (!head_v_q || out_ready);

  // depth counts the array only; the head register adds one slot
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = head_v_q;
  assign out_data  = head_q;

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (load) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // head word register feeds the shifter
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      head_v_q <= 1'b0;
      head_q   <= '0;
    end else if (load) begin
      head_v_q <= 1'b1;
      head_q   <= mem_q[rd_q];
    end else if (out_ready) begin
      head_v_q <= 1'b0;
    end
  end

endmodule

// ==== core/spe_core.sv ====
// serial port engine, master or slave, with its silicon quirks kept
// assumes pins arrive asynchronous; control strobes are one-cycle pulses
//
// Contract
// - slave mode ignores the disable command; port stays enabled
// - mixed divisor one and other, polarity 1, phase 0: one extra pulse
// - keep-active on select 0 with fault detection on: never starts
// - disabling leaves the transmit empty flag as it was
// - transmit writes while disabled are dropped, flag not cleared

`timescale 1ns/1ps

module spe_core
  import spe_pkg::*;
#(
  parameter int W = SPE_WORD_W
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // control strobes
  input  wire logic                  ctl_enable,
  input  wire logic                  ctl_disable,
  input  wire logic                  soft_reset_bit,
  // mode register load
  input  wire logic                  mode_wr,
  input  wire logic                  mode_master,
  input  wire logic                  mode_fault_disable,
  input  wire logic [SPE_CS_W-1:0]   mode_cs_sel,
  // chip select config load
  input  wire logic                  cs_wr,
  input  wire logic [SPE_CS_W-1:0]   cs_idx,
  input  wire logic [SPE_DIV_W-1:0]  serial_clock_divisor,
  input  wire logic                  clock_polarity,
  input  wire logic                  clock_phase_select,
  input  wire logic                  chip_select_keep_active,
  // transmit data register write
  input  wire logic                  transmit_data_wr,
  input  wire logic [W-1:0]          transmit_data_register,
  output logic                       transmit_empty_flag,
  // receive side and status
  input  wire logic                  status_read,
  output logic [W-1:0]               rx_data,
  output logic                       rx_valid,
  output logic                       rx_full_flag,
  output logic                       mode_fault_flag,
  output logic                       enabled_flag,
  output logic                       busy,
  // pins
  input  wire logic                  sck_i,
  output logic                       sck_o,
  output logic                       sck_oe,
  input  wire logic                  mosi_i,
  output logic                       mosi_o,
  output logic                       mosi_oe,
  input  wire logic                  miso_i,
  output logic                       miso_o,
  output logic                       miso_oe,
  input  wire logic                  ss_n_i,
  output logic [SPE_NUM_CS-1:0]      cs_n_o
);

  // ***********************************************************
  // configuration and control state
  // ***********************************************************
  logic                 enabled_q, master_q, mfd_q;
  logic [SPE_CS_W-1:0]  sel_q;
  logic [SPE_DIV_W-1:0] div_q [SPE_NUM_CS];
  logic [SPE_NUM_CS-1:0] cpol_q, phase_q, keep_q, used_q;
  logic                 mode_fault_q, txe_q, rx_full_q, rx_valid_q;
  logic [W-1:0]         rx_data_q, tx_sh_q, rx_sh_q;
  wire                  sres = sys_rst || soft_reset_bit;
  wire                  fault_ev;

  // disable is honoured only by a master; a slave keeps running
  wire dis_take = ctl_disable && master_q;

  always_ff @(posedge clk) begin
    if (sres) begin
      enabled_q <= 1'b0;
    end else if (dis_take || fault_ev) begin
      enabled_q <= 1'b0;
    end else if (ctl_enable) begin
      enabled_q <= 1'b1;
    end
  end

  // mode register
  always_ff @(posedge clk) begin
    if (sres) begin
      master_q <= SPE_MSTR_RESET;
      mfd_q    <= SPE_MFD_RESET;
      sel_q    <= '0;
    end else if (mode_wr) begin
      master_q <= mode_master;
      mfd_q    <= mode_fault_disable;
      sel_q    <= mode_cs_sel;
    end
  end

  // chip select configs; used_q marks selects that were set up
  for (genvar i = 0; i < SPE_NUM_CS; i++) begin : g_cs
    always_ff @(posedge clk) begin
      if (sres) begin
        div_q[i]  <= SPE_DIV_RESET;
        cpol_q[i] <= 1'b0;
        phase_q[i] <= 1'b0;
        keep_q[i] <= 1'b0;
        used_q[i] <= 1'b0;
      end else if (cs_wr && cs_idx == SPE_CS_W'(i)) begin
        div_q[i]  <= serial_clock_divisor;
        cpol_q[i] <= clock_polarity;
        phase_q[i] <= clock_phase_select;
        keep_q[i] <= chip_select_keep_active;
        used_q[i] <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  logic [3:0] meta_q, sync_q;
  logic       sck_p_q, ss_p_q;
  always_ff @(posedge clk) begin
    meta_q <= {sck_i, ss_n_i, mosi_i, miso_i};
    sync_q <= meta_q;
    sck_p_q <= sync_q[3];
    ss_p_q  <= sync_q[2];
  end
  wire sck_s = sync_q[3];
  wire ss_s  = sync_q[2];
  wire mosi_s = sync_q[1];
  wire miso_s = sync_q[0];

  // ***********************************************************
  // decode of the selected chip select
  // ***********************************************************
  function automatic logic div_is_one(input logic [SPE_DIV_W-1:0] d);
    return d == SPE_DIV_ONE;
  endfunction

  logic [SPE_NUM_CS-1:0] is_one, not_one;
  for (genvar i = 0; i < SPE_NUM_CS; i++) begin : g_mix
    assign is_one[i]  = used_q[i] && div_is_one(div_q[i]);
    assign not_one[i] = used_q[i] && !div_is_one(div_q[i]);
  end
  wire [SPE_DIV_W-1:0] div_sel = div_q[sel_q];
  wire cpol_sel  = cpol_q[sel_q];
  wire phase_sel = phase_q[sel_q];
  // the divider mix corrupts the clock only in this polarity and phase
  wire extra_cond = (|is_one) && (|not_one)
                    && cpol_sel && !phase_sel;
  // the hang case blocks every master start, not only select 0
  wire start_block = keep_q[0] && !mfd_q;

  // mode fault: another master pulls our slave select low
  assign fault_ev = master_q && enabled_q && !mfd_q && !ss_s;

  // ***********************************************************
  // transmit buffer and empty flag
  // ***********************************************************
  wire         fifo_in_ready, fifo_out_valid;
  wire [W-1:0] fifo_out_data;
  wire         load_ev;
  wire         fifo_push = transmit_data_wr && enabled_q
                           && fifo_in_ready;

  spe_fifo #(
    .W     (W),
    .DEPTH (SPE_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (soft_reset_bit),
    .in_valid  (fifo_push),
    .in_data   (transmit_data_register),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (load_ev)
  );

  // flag freezes while disabled, so a dma sees room that is not there
  always_ff @(posedge clk) begin
    if (sres) begin
      txe_q <= SPE_TXE_RESET;
    end else if (enabled_q) begin
      txe_q <= fifo_in_ready && !fifo_push;
    end
  end

  // ***********************************************************
  // master sequencer
  // ***********************************************************
  spe_state_type        st_q;
  logic [SPE_DIV_W-1:0] cnt_q;
  logic [4:0]           half_q;
  logic                 sck_q, hold_q;
  logic [SPE_NUM_CS-1:0] cs_n_q;
  wire [SPE_DIV_W-1:0] div_eff = (div_sel == '0) ? SPE_DIV_ONE : div_sel;
  wire tick    = (cnt_q + 1'b1) >= div_eff;
  wire run_m   = master_q && enabled_q;
  wire start_m = run_m && st_q == SPE_ST_IDLE && fifo_out_valid
                 && !start_block;
  wire in_sh   = st_q == SPE_ST_SHIFT && tick;
  wire m_lead  = in_sh && !half_q[0];
  wire m_trail = in_sh && half_q[0];
  wire m_done  = in_sh && half_q == SPE_LAST_HALF;
  wire m_sample = phase_sel ? m_lead : m_trail;
  wire m_shift  = phase_sel ? (m_trail && !m_done)
                            : (m_lead && half_q != 5'h00);

  always_ff @(posedge clk) begin
    if (sres || !run_m) begin
      st_q   <= SPE_ST_IDLE;
      half_q <= '0;
      cnt_q  <= '0;
    end else begin
      cnt_q <= (st_q == SPE_ST_IDLE || tick) ? '0 : cnt_q + 1'b1;
      case (st_q)
        SPE_ST_IDLE: begin
          half_q <= '0;
          if (start_m) begin
            st_q <= extra_cond ? SPE_ST_EXTRA : SPE_ST_SHIFT;
          end
        end
        SPE_ST_EXTRA: begin
          if (tick) begin
            half_q <= (half_q == SPE_LAST_EXTRA) ? '0 : half_q + 1'b1;
            if (half_q == SPE_LAST_EXTRA) st_q <= SPE_ST_SHIFT;
          end
        end
        SPE_ST_SHIFT: begin
          if (tick) begin
            half_q <= half_q + 1'b1;
            if (m_done) st_q <= SPE_ST_IDLE;
          end
        end
        default: st_q <= SPE_ST_IDLE;
      endcase
    end
  end

  // clock line toggles on every tick outside idle, extra pulse included
  always_ff @(posedge clk) begin
    if (sres || st_q == SPE_ST_IDLE) begin
      sck_q <= sres ? 1'b0 : cpol_sel;
    end else if (tick) begin
      sck_q <= ~sck_q;
    end
  end

  // selects stay low after a word when keep-active is set
  always_ff @(posedge clk) begin
    if (sres || !run_m) begin
      hold_q <= 1'b0;
      cs_n_q <= '1;
    end else begin
      if (m_done) hold_q <= keep_q[sel_q];
      for (int i = 0; i < SPE_NUM_CS; i++) begin
        cs_n_q[i] <= !(sel_q == SPE_CS_W'(i)
                       && (st_q != SPE_ST_IDLE || hold_q || start_m));
      end
    end
  end

  // ***********************************************************
  // slave edge decode
  // ***********************************************************
  logic [2:0] sbits_q;
  wire slv_act  = !master_q && enabled_q && !ss_s;
  wire s_edge   = slv_act && (sck_s != sck_p_q);
  wire s_lead   = s_edge && (sck_s != cpol_q[0]);
  wire s_trail  = s_edge && !s_lead;
  wire s_sample = phase_q[0] ? s_lead : s_trail;
  wire s_shift  = (phase_q[0] ? s_trail : s_lead) && sbits_q != 3'h0;
  wire s_done   = s_sample && sbits_q == SPE_LAST_BIT;
  wire s_load   = slv_act && (ss_p_q || s_done);

  always_ff @(posedge clk) begin
    if (sres || !slv_act) begin
      sbits_q <= '0;
    end else if (s_sample) begin
      sbits_q <= sbits_q + 1'b1;
    end
  end

  // ***********************************************************
  // shared shifters and receive holding register
  // ***********************************************************
  wire         sample_ev = master_q ? m_sample : s_sample;
  wire         shift_ev  = master_q ? m_shift : s_shift;
  wire         done_ev   = master_q ? m_done : s_done;
  assign       load_ev   = master_q ? start_m : (s_load && fifo_out_valid);
  wire         in_bit    = master_q ? miso_s : mosi_s;
  wire [W-1:0] rx_next   = {rx_sh_q[W-2:0], in_bit};
  wire [W-1:0] rx_word   = sample_ev ? rx_next : rx_sh_q;
  // slave with an empty buffer sends zeros
  wire [W-1:0] tx_load   = fifo_out_valid ? fifo_out_data : '0;

  always_ff @(posedge clk) begin
    if (sres) begin
      tx_sh_q <= '0;
      rx_sh_q <= '0;
    end else begin
      if (load_ev || s_load) tx_sh_q <= tx_load;
      else if (shift_ev) tx_sh_q <= {tx_sh_q[W-2:0], 1'b0};
      if (sample_ev) rx_sh_q <= rx_next;
    end
  end

  // received word and sticky flags; a new event beats a status clear
  always_ff @(posedge clk) begin
    if (sres) begin
      rx_data_q    <= '0;
      rx_valid_q   <= 1'b0;
      rx_full_q    <= 1'b0;
      mode_fault_q <= 1'b0;
    end else begin
      rx_valid_q <= done_ev;
      if (done_ev) rx_data_q <= rx_word;
      rx_full_q    <= done_ev || (rx_full_q && !status_read);
      mode_fault_q <= fault_ev || (mode_fault_q && !status_read);
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign transmit_empty_flag = txe_q;
  assign rx_data         = rx_data_q;
  assign rx_valid        = rx_valid_q;
  assign rx_full_flag    = rx_full_q;
  assign mode_fault_flag = mode_fault_q;
  assign enabled_flag    = enabled_q;
  assign busy            = (st_q != SPE_ST_IDLE) || (sbits_q != 3'h0);
  assign sck_o   = sck_q;
  assign sck_oe  = run_m;
  assign mosi_o  = tx_sh_q[W-1];
  assign mosi_oe = run_m;
  assign miso_o  = tx_sh_q[W-1];
  assign miso_oe = slv_act;
  assign cs_n_o  = cs_n_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  slave_keeps_en_a: assert property (@(posedge clk) disable iff (sys_rst)
    !master_q && enabled_q && ctl_disable && !soft_reset_bit && !mode_wr
    |=> enabled_q)
    else $error("slave port dropped enable on disable");

  extra_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    start_m && extra_cond && !soft_reset_bit
    |=> st_q == SPE_ST_EXTRA)
    else $error("mixed divisor start skipped the extra pulse");

  no_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_q == SPE_ST_IDLE && start_block |=> st_q == SPE_ST_IDLE)
    else $error("transfer began with keep-active and fault detection");

  txe_frozen_a: assert property (@(posedge clk) disable iff (sys_rst)
    !enabled_q && !soft_reset_bit
    |=> transmit_empty_flag == $past(transmit_empty_flag))
    else $error("transmit empty flag moved while disabled");

  drop_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    transmit_data_wr && !enabled_q |-> !fifo_push ##1 transmit_empty_flag
      == $past(transmit_empty_flag))
    else $error("write taken while port disabled");

  soft_reset_bit_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    soft_reset_bit |=> !enabled_q && st_q == SPE_ST_IDLE && !master_q
      && transmit_empty_flag && !mode_fault_q && !rx_full_q)
    else $error("soft reset left state behind");

endmodule

// ==== dv/spe_peer_model.sv ====
// far-side serial slave that answers the port's master pins
// assumes clock polarity 0 and capture on the leading edge

`timescale 1ns/1ps

module spe_peer_model (
  // pins
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  // bench side
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte,
  output int              n_words
);
  logic [7:0] sh_q;
  int         bits;

  // ***********************************************************
  // shifter
  // ***********************************************************
  initial begin
    miso    = 1'b0;
    rx_byte = 8'h00;
    n_words = 0;
    bits    = 0;
    sh_q    = 8'h00;
  end
  // load on select so the first bit is ready before the leading edge
  always @(negedge cs_n) begin
    sh_q = tx_byte;
    miso = tx_byte[7];
    bits = 0;
  end
  always @(posedge sck) if (!cs_n) begin
    rx_byte = {rx_byte[6:0], mosi};
    bits++;
    if (bits == 8) begin
      bits = 0;
      n_words++;
    end
  end
  // next bit on the trailing edge; a held select reloads the word
  always @(negedge sck) if (!cs_n) begin
    sh_q = (bits == 0) ? tx_byte : {sh_q[6:0], 1'b0};
    miso = sh_q[7];
  end
  // a released line carries nothing stable
  always #7 if (cs_n) miso = ~miso;
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for the serial port engine and its quirks
// assumes the core alone; the bench plays software, dma and a master

`timescale 1ns/1ps

module tb_top;
  import spe_pkg::*;

  // ***********************************************************
  // signals and model state
  // ***********************************************************
  logic       clk = 1'b0, sys_rst = 1'b1;
  logic       ctl_enable = 1'b0, ctl_disable = 1'b0;
  logic       soft_reset_bit = 1'b0, status_read = 1'b0;
  logic       mode_wr = 1'b0, mode_master = 1'b0, mode_fault_disable = 1'b0;
  logic [1:0] mode_cs_sel = 2'h0, cs_idx = 2'h0;
  logic       cs_wr = 1'b0, clock_polarity = 1'b0, clock_phase_select = 1'b0;
  logic       chip_select_keep_active = 1'b0, transmit_data_wr = 1'b0;
  logic [7:0] serial_clock_divisor = 8'h00, transmit_data_register = 8'h00;
  logic       bsck = 1'b0, bmosi = 1'b0, ss_n_i = 1'b1, pmiso;
  logic       transmit_empty_flag, rx_valid, rx_full_flag, mode_fault_flag;
  logic       enabled_flag, busy, sck_o, sck_oe, mosi_o, mosi_oe;
  logic       miso_o, miso_oe, prev;
  logic [7:0] rx_data, peer_byte = 8'h00, b, so_byte = 8'h00;
  logic [3:0] cs_n_o;
  logic [7:0] txq[$], got_rx[$];
  int         n_errors = 0, comparisons = 0, nw = 0, cyc = 0, nf, bad;
  logic       m_en = 1'b0, m_master = 1'b0;
  // each pin level resolves from whoever drives it
  wire sck_w  = sck_oe ? sck_o : bsck;
  wire mosi_w = mosi_oe ? mosi_o : bmosi;
  wire miso_w = miso_oe ? miso_o : pmiso;

  always #2.5 clk = ~clk;

  spe_core DUT (.clk(clk), .sys_rst(sys_rst), .ctl_enable(ctl_enable),
    .ctl_disable(ctl_disable), .soft_reset_bit(soft_reset_bit),
    .mode_wr(mode_wr), .mode_master(mode_master),
    .mode_fault_disable(mode_fault_disable), .mode_cs_sel(mode_cs_sel),
    .cs_wr(cs_wr), .cs_idx(cs_idx),
    .serial_clock_divisor(serial_clock_divisor),
    .clock_polarity(clock_polarity), .clock_phase_select(clock_phase_select),
    .chip_select_keep_active(chip_select_keep_active),
    .transmit_data_wr(transmit_data_wr),
    .transmit_data_register(transmit_data_register),
    .transmit_empty_flag(transmit_empty_flag),
    .status_read(status_read), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_full_flag(rx_full_flag), .mode_fault_flag(mode_fault_flag),
    .enabled_flag(enabled_flag), .busy(busy), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n_i),
    .cs_n_o(cs_n_o));

  spe_peer_model peer (.sck(sck_w), .cs_n(cs_n_o[0]), .mosi(mosi_w),
    .miso(pmiso), .tx_byte(peer_byte), .rx_byte(), .n_words());

  // rx_valid stands one cycle, so it is taken mid-cycle
  always @(negedge clk) if (rx_valid === 1'b1) got_rx.push_back(rx_data);

  // ***********************************************************
  // tasks
  // ***********************************************************
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic ctl(input logic en, dis, rs, rd);
    @(negedge clk);
    {ctl_enable, ctl_disable, soft_reset_bit, status_read} = {en, dis, rs, rd};
    @(negedge clk);
    {ctl_enable, ctl_disable, soft_reset_bit, status_read} = 4'h0;
    if (en) m_en = 1'b1;
    // slave mode keeps running through a disable
    if (dis && m_master) m_en = 1'b0;
    if (rs) begin
      m_en = 1'b0;
      m_master = 1'b0;
      txq.delete();
      got_rx.delete();
    end
  endtask
  task automatic mode(input logic m, f, input logic [1:0] s);
    @(negedge clk);
    {mode_wr, mode_master, mode_fault_disable, mode_cs_sel} = {1'b1, m, f, s};
    @(negedge clk);
    mode_wr = 1'b0;
    m_master = m;
  endtask
  task automatic csc(input logic [1:0] i, input logic [7:0] d,
                     input logic p, ph, k);
    @(negedge clk);
    {cs_wr, cs_idx, serial_clock_divisor} = {1'b1, i, d};
    {clock_polarity, clock_phase_select, chip_select_keep_active} = {p, ph, k};
    @(negedge clk);
    cs_wr = 1'b0;
  endtask
  // the model drops words written while disabled
  task automatic put_tx(input logic [7:0] d);
    @(negedge clk);
    {transmit_data_wr, transmit_data_register} = {1'b1, d};
    @(negedge clk);
    transmit_data_wr = 1'b0;
    if (m_en) txq.push_back(d);
  endtask
  task automatic get_rx(input logic [7:0] e);
    int k;
    k = 0;
    while (got_rx.size() == 0 && k < 40) begin
      @(negedge clk);
      k++;
    end
    check((got_rx.size() > 0) ? got_rx.pop_front() : ~e, e, "received word");
  endtask
  task automatic word_done;
    int k;
    k = 0;
    while (peer.n_words == nw && k < 20000) begin
      @(negedge clk);
      k++;
    end
    nw++;
    check(peer.rx_byte, (txq.size() > 0) ? txq.pop_front() : 8'hxx, "line");
    get_rx(peer_byte);
  endtask
  task automatic slave_frame(input logic [7:0] d);
    @(negedge clk);
    #1 ss_n_i = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      bmosi = d[i];
      #62.5 bsck = 1'b1;
      so_byte = {so_byte[6:0], miso_w};
      #62.5 bsck = 1'b0;
    end
    #62.5 ss_n_i = 1'b1;
    bmosi = ~bmosi;
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("Error at %0t: run timed out", $time);
      give_verdict();
    end
  end

  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial begin
    void'($urandom(83));
    repeat (16) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check(enabled_flag, 1'b0, "enable at reset");
    check(transmit_empty_flag, 1'b1, "empty at reset");
    check(cs_n_o, 4'hf, "selects at reset");
    // master words back to back, then a disable with the flag high
    mode(1'b1, 1'b1, 2'h0);
    csc(2'h0, 8'h04, 1'b0, 1'b1, 1'b0);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    peer_byte = 8'($urandom);
    for (int i = 0; i < 3; i++) put_tx(8'($urandom));
    repeat (3) word_done();
    repeat (2) @(negedge clk);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    check(enabled_flag, 1'b0, "master disable");
    check({sck_oe, mosi_oe, miso_oe}, 3'h0, "pin drives off");
    check(transmit_empty_flag, 1'b1, "flag kept high");
    for (int i = 0; i < 3; i++) put_tx(8'($urandom));
    check(transmit_empty_flag, 1'b1, "flag after drops");
    repeat (200) @(negedge clk);
    check(8'(peer.n_words), 8'(nw), "dropped words");
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    put_tx(8'($urandom));
    word_done();
    // fill the buffer on a slow divisor, then disable with the flag low
    csc(2'h0, 8'hff, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 20; i++) put_tx(8'($urandom));
    check(transmit_empty_flag, 1'b0, "buffer full");
    repeat (2) @(negedge clk);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (8) @(negedge clk);
    check(transmit_empty_flag, 1'b0, "flag kept low");
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    check(transmit_empty_flag, 1'b1, "flag restored");
    check(busy, 1'b0, "transfer aborted");
    check(cs_n_o, 4'hf, "selects released");
    // keep-active on select 0 with fault detection on never starts
    mode(1'b1, 1'b0, 2'h0);
    csc(2'h0, 8'h04, 1'b0, 1'b1, 1'b1);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    put_tx(8'($urandom));
    bad = 0;
    repeat (100) @(negedge clk) if (busy !== 1'b0 || cs_n_o !== 4'hf) bad++;
    check(8'(bad), 8'h00, "stalled start");
    // another master pulling the select low trips the fault detector
    ss_n_i = 1'b0;
    repeat (6) @(negedge clk);
    check(mode_fault_flag, 1'b1, "mode fault seen");
    check(enabled_flag, 1'b0, "fault disables");
    ss_n_i = 1'b1;
    repeat (4) @(negedge clk);
    ctl(1'b1, 1'b0, 1'b0, 1'b1);
    check(mode_fault_flag, 1'b0, "fault flag read");
    mode(1'b1, 1'b1, 2'h0);
    word_done();
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    // mixed divisors give one extra pulse, equal divisors none
    mode(1'b1, 1'b1, 2'h1);
    csc(2'h0, 8'h01, 1'b1, 1'b0, 1'b0);
    csc(2'h1, 8'h02, 1'b1, 1'b0, 1'b0);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) csc(2'h1, 8'h01, 1'b1, 1'b0, 1'b0);
      put_tx(8'($urandom));
      nf = 0;
      prev = sck_o;
      repeat (200) @(negedge clk) begin
        if (prev === 1'b1 && sck_o === 1'b0) nf++;
        prev = sck_o;
      end
      check(8'(nf), 8'(9 - k), "clock pulses");
    end
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    // slave ignores disable; read last word, then soft reset
    mode(1'b0, 1'b1, 2'h0);
    csc(2'h0, 8'h01, 1'b0, 1'b1, 1'b0);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    check(enabled_flag, 1'b1, "slave disable ignored");
    put_tx(8'($urandom));
    b = 8'($urandom);
    slave_frame(b);
    check(so_byte, txq.pop_front(), "slave out");
    get_rx(b);
    check(rx_full_flag, 1'b1, "receive full");
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
    check(rx_full_flag, 1'b0, "receive read");
    ctl(1'b0, 1'b0, 1'b1, 1'b0);
    check(enabled_flag, 1'b0, "slave stopped");
    give_verdict();
  end
endmodule
